// ---- hw/config_word_decode.sv ----
// Configuration word latch, decoder and run-time feature control with an APB slave.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module config_word_decode
    import config_word_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [13:0] OSC_WORD,
    input wire logic [13:0] SUP_WORD,
    input wire logic LOW_VOLTAGE_PROGRAMMING,
    input wire logic CODE_GUARD_BIT,
    input wire logic SLEEP,
    input wire logic STACK_OVERFLOW,
    input wire logic STACK_UNDERFLOW,
    input wire logic SHARED_INPUT_PIN,
    output logic CONFIG_VALID,
    output osc_cfg_t OSC_CFG,
    output sup_cfg_t SUP_CFG,
    output logic [2:0] CURRENT_OSCILLATOR,
    output logic [3:0] CURRENT_DIVIDER,
    output logic ZERO_CROSS_ON,
    output logic BROWNOUT_ON,
    output logic REMAP_LOCKED,
    output logic STACK_RESET,
    output logic EXTERNAL_RESET,
    output logic SHARED_INPUT_VALUE
);

    generate
        if (ADDR_W < 5 || ADDR_W > 12) begin : g_bad_addr
            $error("ADDR_W must lie between 5 and 12.");
        end
    endgenerate

    typedef struct packed {
        phase_t phase;
        logic [13:0] osc_word;
        logic [13:0] sup_word;
        osc_cfg_t osc;
        sup_cfg_t sup;
        logic [2:0] new_osc;
        logic [3:0] new_div;
        logic [2:0] cur_osc;
        logic [3:0] cur_div;
        logic zcd_soft;
        logic bor_soft;
        logic remap_lock;
        logic remap_stuck;
        logic stk_ovf;
        logic stk_unf;
        logic stack_reset;
        logic zcd_on;
        logic bor_on;
        logic ext_reset;
        logic gp_value;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_t;

    function automatic osc_cfg_t decode_osc(input logic [13:0] w);
        osc_cfg_t c;
        logic [2:0] ext;
        logic [2:0] rst;
        ext = w[OSC_EXT_LSB +: 3];
        rst = w[OSC_RST_LSB +: 3];
        c = '0;
        c.clock_fail_monitor_on = w[OSC_FAIL_MON_BIT]; // R3
        c.clock_switch_allow = w[OSC_SWITCH_BIT]; // R4
        c.reset_oscillator_choice = rst; // R6
        c.external_oscillator_mode = ext; // R9
        c.internal_frequency_code = FRQ_4M;
        c.clock_divider_code = DIV_BY_1;
        c.source = SRC_FAST_INTERNAL;
        unique case (rst)
            RST_EXTERNAL: c.source = SRC_EXTERNAL; // R6
            RST_SLOW: c.source = SRC_SLOW_INTERNAL; // R6
            RST_FAST_1M: c.clock_divider_code = DIV_BY_4; // R7
            RST_EXT_PLL4: begin
                c.source = SRC_EXTERNAL; // R7
                c.pll_x4 = 1'b1;
            end
            RST_FAST_PLL2: begin
                c.pll_x2 = 1'b1; // R8
                c.internal_frequency_code = FRQ_16M;
            end
            RST_FAST_32M: c.internal_frequency_code = FRQ_32M; // R8
            // Reserved codes fall back to the plain fast internal setup.
            default: c.source = SRC_FAST_INTERNAL;
        endcase
        unique case (ext)
            EXT_CLK_HIGH: c.flash_power_level = FLASH_PWR_HIGH; // R9
            EXT_CLK_MID: c.flash_power_level = FLASH_PWR_MID; // R9
            XTAL_FAST: c.flash_power_level = FLASH_PWR_HIGH; // R10
            XTAL_MID: c.flash_power_level = FLASH_PWR_MID; // R10
            default: c.flash_power_level = FLASH_PWR_LOW; // R10
        endcase
        c.external_clock_input_mode = (ext == EXT_CLK_HIGH) || (ext == EXT_CLK_MID)
            || (ext == EXT_CLK_LOW); // R9
        c.crystal_mode = (ext == XTAL_FAST) || (ext == XTAL_MID) || (ext == XTAL_WATCH); // R10
        // A crystal needs the second pin, so the clock output is only honoured otherwise.
        c.clock_output_active = (c.external_clock_input_mode || ext == EXT_OFF)
            && !w[OSC_CLKOUT_BIT]; // R5
        return c;
    endfunction : decode_osc

    function automatic sup_cfg_t decode_sup(input logic [13:0] w, input logic low_voltage_programming,
                                            input logic guard);
        sup_cfg_t c;
        c.debugger_on = !w[SUP_DEBUG_BIT]; // R11
        c.stack_fault_reset_on = w[SUP_STACK_BIT]; // R12
        c.remap_lock_once = w[SUP_REMAP_BIT]; // R13
        c.zero_cross_off = w[SUP_ZCD_BIT]; // R14
        c.brownout_level = w[SUP_BROWNOUT_LEVEL_BIT]; // R15
        c.brownout_mode = w[SUP_BROWNOUT_MODE_LSB +: 2]; // R16
        c.ultra_low_brownout_on = !w[SUP_LPBOR_BIT]; // R17
        c.powerup_timer_on = !w[SUP_PWRT_BIT]; // R18
        c.reset_pin_function = low_voltage_programming || w[SUP_RSTPIN_BIT]; // R19 R20
        c.high_voltage_programming = !low_voltage_programming; // R20
        c.code_guard_on = !guard; // R21
        return c;
    endfunction : decode_sup

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        return a == off[ADDR_W-1:0];
    endfunction : hit

    // A blank part reads all ones, so reset shows the blank-part defaults, except BROWNOUT_ON, which resets low.
    function automatic state_t reset_state();
        state_t s;
        s = '0;
        s.phase = PH_LOAD;
        s.osc_word = BLANK_WORD;
        s.sup_word = BLANK_WORD;
        s.osc = decode_osc(BLANK_WORD);
        s.sup = decode_sup(BLANK_WORD, 1'b1, 1'b1);
        s.new_osc = s.osc.reset_oscillator_choice;
        s.new_div = s.osc.clock_divider_code;
        s.cur_osc = s.osc.reset_oscillator_choice;
        s.cur_div = s.osc.clock_divider_code;
        s.gp_value = 1'b1;
        return s;
    endfunction : reset_state

    localparam state_t ST_RESET = reset_state();

    state_t s_r;
    state_t s_nxt;
    logic access;
    logic wr;
    logic mapped;

    assign access = PSEL && PENABLE && s_r.pready;
    assign wr = access && PWRITE;
    assign mapped = hit(PADDR, REG_OSC_WORD) || hit(PADDR, REG_SUP_WORD)
        || hit(PADDR, REG_PROG_WORD) || hit(PADDR, REG_CLOCK_CTRL)
        || hit(PADDR, REG_FEATURE_CTRL) || hit(PADDR, REG_STATUS);

    always_comb begin
        s_nxt = s_r;
        s_nxt.stack_reset = 1'b0;
        if (s_r.phase == PH_LOAD) begin
            // Words are sampled in the first cycle after reset release, before the core runs.
            s_nxt.phase = PH_RUN; // R1 R23
            s_nxt.osc_word = OSC_WORD | OSC_UNUSED_MASK; // R2
            s_nxt.sup_word = SUP_WORD | SUP_UNUSED_MASK; // R2
            s_nxt.osc = decode_osc(OSC_WORD);
            s_nxt.sup = decode_sup(SUP_WORD, LOW_VOLTAGE_PROGRAMMING, CODE_GUARD_BIT);
            s_nxt.cur_osc = OSC_WORD[OSC_RST_LSB +: 3]; // R6
            s_nxt.cur_div = s_nxt.osc.clock_divider_code;
            s_nxt.new_osc = s_nxt.cur_osc;
            s_nxt.new_div = s_nxt.cur_div;
        end else begin
            // A clock switch is taken as complete one cycle after it is requested.
            s_nxt.cur_osc = s_r.new_osc;
            s_nxt.cur_div = s_r.new_div;
        end

        // Bus slave with one wait state; the write lands on the edge that ends the access.
        s_nxt.pready = PSEL && PENABLE && !s_r.pready;
        s_nxt.pslverr = PSEL && PENABLE && !s_r.pready && !mapped;
        s_nxt.prdata = '0;
        if (PSEL && PENABLE && !s_r.pready && !PWRITE) begin
            if (hit(PADDR, REG_OSC_WORD)) begin
                s_nxt.prdata[13:0] = s_r.osc_word; // R2
            end else if (hit(PADDR, REG_SUP_WORD)) begin
                s_nxt.prdata[13:0] = s_r.sup_word; // R2
            end else if (hit(PADDR, REG_PROG_WORD)) begin
                s_nxt.prdata[PROG_LVP_BIT] = !s_r.sup.high_voltage_programming;
                s_nxt.prdata[PROG_GUARD_BIT] = !s_r.sup.code_guard_on;
            end else if (hit(PADDR, REG_CLOCK_CTRL)) begin
                s_nxt.prdata[CLK_NEWOSC_LSB +: 3] = s_r.new_osc;
                s_nxt.prdata[CLK_NEWDIV_LSB +: 4] = s_r.new_div;
                s_nxt.prdata[CLK_CUROSC_LSB +: 3] = s_r.cur_osc;
                s_nxt.prdata[CLK_CURDIV_LSB +: 4] = s_r.cur_div;
            end else if (hit(PADDR, REG_FEATURE_CTRL)) begin
                s_nxt.prdata[FEAT_ZCD_SOFT_BIT] = s_r.zcd_soft;
                s_nxt.prdata[FEAT_BOR_SOFT_BIT] = s_r.bor_soft;
                s_nxt.prdata[FEAT_LOCK_BIT] = s_r.remap_lock;
            end else if (hit(PADDR, REG_STATUS)) begin
                s_nxt.prdata[STAT_OVF_BIT] = s_r.stk_ovf;
                s_nxt.prdata[STAT_UNF_BIT] = s_r.stk_unf;
                s_nxt.prdata[STAT_VALID_BIT] = s_r.phase == PH_RUN;
                s_nxt.prdata[STAT_STUCK_BIT] = s_r.remap_stuck;
            end
        end

        if (wr && hit(PADDR, REG_CLOCK_CTRL) && s_r.osc.clock_switch_allow) begin
            s_nxt.new_osc = PWDATA[CLK_NEWOSC_LSB +: 3]; // R4
            s_nxt.new_div = PWDATA[CLK_NEWDIV_LSB +: 4]; // R4
        end
        if (wr && hit(PADDR, REG_FEATURE_CTRL)) begin
            s_nxt.zcd_soft = PWDATA[FEAT_ZCD_SOFT_BIT];
            s_nxt.bor_soft = PWDATA[FEAT_BOR_SOFT_BIT];
            if (!s_r.remap_stuck) begin
                s_nxt.remap_lock = PWDATA[FEAT_LOCK_BIT]; // R13
                s_nxt.remap_stuck = PWDATA[FEAT_LOCK_BIT] && s_r.sup.remap_lock_once; // R13
            end
        end
        // Flags clear by writing one; a fault in the same cycle keeps its flag set.
        if (wr && hit(PADDR, REG_STATUS)) begin
            s_nxt.stk_ovf = s_r.stk_ovf && !PWDATA[STAT_OVF_BIT];
            s_nxt.stk_unf = s_r.stk_unf && !PWDATA[STAT_UNF_BIT];
        end
        if (s_r.phase == PH_RUN) begin
            s_nxt.stk_ovf = s_nxt.stk_ovf || STACK_OVERFLOW; // R22
            s_nxt.stk_unf = s_nxt.stk_unf || STACK_UNDERFLOW; // R22
            s_nxt.stack_reset = s_r.sup.stack_fault_reset_on
                && (STACK_OVERFLOW || STACK_UNDERFLOW); // R12 R22
        end

        s_nxt.zcd_on = !s_r.sup.zero_cross_off || s_r.zcd_soft; // R14
        unique case (s_r.sup.brownout_mode)
            BOR_ALWAYS: s_nxt.bor_on = 1'b1; // R16
            BOR_AWAKE: s_nxt.bor_on = !SLEEP; // R16
            BOR_SOFT: s_nxt.bor_on = s_r.bor_soft; // R16
            BOR_OFF: s_nxt.bor_on = 1'b0; // R16
        endcase
        s_nxt.ext_reset = s_r.sup.reset_pin_function && !SHARED_INPUT_PIN; // R19 R20
        s_nxt.gp_value = s_r.sup.reset_pin_function || SHARED_INPUT_PIN; // R19
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            s_r <= ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign PRDATA = s_r.prdata;
    assign PREADY = s_r.pready;
    assign PSLVERR = s_r.pslverr;
    assign CONFIG_VALID = s_r.phase == PH_RUN;
    assign OSC_CFG = s_r.osc;
    assign SUP_CFG = s_r.sup;
    assign CURRENT_OSCILLATOR = s_r.cur_osc;
    assign CURRENT_DIVIDER = s_r.cur_div;
    assign ZERO_CROSS_ON = s_r.zcd_on;
    assign BROWNOUT_ON = s_r.bor_on;
    assign REMAP_LOCKED = s_r.remap_lock;
    assign STACK_RESET = s_r.stack_reset;
    assign EXTERNAL_RESET = s_r.ext_reset;
    assign SHARED_INPUT_VALUE = s_r.gp_value;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    chk_load_once_run: assert property ( // R1
        s_r.phase == PH_LOAD |=> s_r.phase == PH_RUN
            && s_r.osc_word == ($past(OSC_WORD) | OSC_UNUSED_MASK))
        else $error("Configuration not loaded in the first cycle.");

    chk_unused_read_one: assert property ( // R2
        access && !PWRITE && hit(PADDR, REG_SUP_WORD)
            |-> (PRDATA[13:0] & SUP_UNUSED_MASK) == SUP_UNUSED_MASK && PRDATA[31:14] == '0)
        else $error("Unused configuration bits do not read as one.");

    chk_fail_monitor_bit: assert property ( // R3
        s_r.phase == PH_RUN |-> OSC_CFG.clock_fail_monitor_on == s_r.osc_word[OSC_FAIL_MON_BIT])
        else $error("Fail monitor enable does not follow its bit.");

    chk_switch_gate_held: assert property ( // R4
        wr && hit(PADDR, REG_CLOCK_CTRL) && !s_r.osc.clock_switch_allow
            |=> s_r.new_osc == $past(s_r.new_osc) && s_r.new_div == $past(s_r.new_div))
        else $error("Oscillator fields changed while switching is locked.");

    chk_clock_out_pin: assert property ( // R5
        s_r.phase == PH_RUN && s_r.osc.crystal_mode |-> !OSC_CFG.clock_output_active)
        else $error("Clock output active in a crystal mode.");

    chk_stack_reset_pulse: assert property ( // R12
        s_r.phase == PH_RUN && STACK_OVERFLOW
            |=> STACK_RESET == $past(s_r.sup.stack_fault_reset_on) && s_r.stk_ovf
            ##1 !STACK_RESET || $past(STACK_OVERFLOW || STACK_UNDERFLOW))
        else $error("Stack fault reset or flag wrong.");

    chk_zero_cross_forced: assert property ( // R14
        !s_r.sup.zero_cross_off && s_r.phase == PH_RUN |=> ZERO_CROSS_ON)
        else $error("Zero-cross detector not forced on.");

    chk_brownout_awake: assert property ( // R16
        s_r.sup.brownout_mode == BOR_AWAKE && $stable(s_r.sup) && SLEEP |=> !BROWNOUT_ON)
        else $error("Brown-out active in sleep for run-only mode.");

    chk_reset_pin_fn: assert property ( // R19
        s_r.sup.reset_pin_function && !SHARED_INPUT_PIN |=> EXTERNAL_RESET && SHARED_INPUT_VALUE)
        else $error("Shared pin low did not request a reset.");

    chk_remap_stuck: assert property ( // R13
        s_r.remap_stuck |=> REMAP_LOCKED [*2])
        else $error("Remap lock released after a once-only cycle.");

    chk_bus_wait_state: assert property (
        PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("Bus answer not exactly one wait state.");

endmodule : config_word_decode

// ---- hw/config_word_pkg.sv ----
// Constants, carriers and field layout of the configuration word decoder.
// Behaviour
// R1: Apply configuration before software runs; words at 8007h.
// R2: Unimplemented word bits read back as one.
// R3: Oscillator bit 13 enables fail-safe clock monitor.
// R4: Oscillator bit 11 permits new oscillator/divider writes.
// R5: Bit 8 low drives Fosc/4 out, external-clock or off.
// R6: Bits 6-4 give current oscillator reset value.
// R7: Code 110 internal 4 MHz divide 4; 010 external x4.
// R8: Code 001 internal x2 PLL; 000 internal 32 MHz.
// R9: Bits 2-0 pick external clock modes or off.
// R10: Crystal codes 010 fast, 001 mid, 000 watch.
// R11: Supervisor bit 13 low enables background debugger.
// R12: Supervisor bit 12 makes stack faults reset device.
// R13: Bit 11 allows one lock cycle, then stays locked.
// R14: Bit 10 low forces zero-cross detector on.
// R15: Bit 9 one lower brown-out level, zero higher.
// R16: Bits 7-6 choose brown-out on, run-only, software, off.
// R17: Bit 5 low enables ultra-low-power brown-out detector.
// R18: Bit 1 low enables the power-up timer.
// R19: Shared pin resets if low-voltage programming or bit 0.
// R20: Low-voltage programming forces reset pin; else high voltage.
// R21: Code guard bit zero protects program memory.
// R22: Stack overflow/underflow sets its flag and may reset.
// R23: Decoded settings latched at reset, blank gives defaults.
package config_word_pkg;

    localparam int WORD_W = 14;
    localparam logic [15:0] CONFIG_BASE_ADDR = 16'h8007;
    localparam logic [13:0] BLANK_WORD = 14'h3fff;
    localparam logic [13:0] OSC_UNUSED_MASK = 14'h1688;
    localparam logic [13:0] SUP_UNUSED_MASK = 14'h011c;

    // Oscillator word field positions.
    localparam int OSC_FAIL_MON_BIT = 13;
    localparam int OSC_SWITCH_BIT = 11;
    localparam int OSC_CLKOUT_BIT = 8;
    localparam int OSC_RST_LSB = 4;
    localparam int OSC_EXT_LSB = 0;

    // Supervisor word field positions.
    localparam int SUP_DEBUG_BIT = 13;
    localparam int SUP_STACK_BIT = 12;
    localparam int SUP_REMAP_BIT = 11;
    localparam int SUP_ZCD_BIT = 10;
    localparam int SUP_BROWNOUT_LEVEL_BIT = 9;
    localparam int SUP_BROWNOUT_MODE_LSB = 6;
    localparam int SUP_LPBOR_BIT = 5;
    localparam int SUP_PWRT_BIT = 1;
    localparam int SUP_RSTPIN_BIT = 0;

    // Reset oscillator choices.
    localparam logic [2:0] RST_EXTERNAL = 3'h7;
    localparam logic [2:0] RST_FAST_1M = 3'h6;
    localparam logic [2:0] RST_SLOW = 3'h5;
    localparam logic [2:0] RST_EXT_PLL4 = 3'h2;
    localparam logic [2:0] RST_FAST_PLL2 = 3'h1;
    localparam logic [2:0] RST_FAST_32M = 3'h0;
    localparam logic [2:0] FRQ_4M = 3'h2;
    localparam logic [2:0] FRQ_16M = 3'h5;
    localparam logic [2:0] FRQ_32M = 3'h6;
    localparam logic [3:0] DIV_BY_4 = 4'h2;
    localparam logic [3:0] DIV_BY_1 = 4'h0;

    // External oscillator modes.
    localparam logic [2:0] EXT_CLK_HIGH = 3'h7;
    localparam logic [2:0] EXT_CLK_MID = 3'h6;
    localparam logic [2:0] EXT_CLK_LOW = 3'h5;
    localparam logic [2:0] EXT_OFF = 3'h4;
    localparam logic [2:0] XTAL_FAST = 3'h2;
    localparam logic [2:0] XTAL_MID = 3'h1;
    localparam logic [2:0] XTAL_WATCH = 3'h0;
    localparam logic [1:0] FLASH_PWR_HIGH = 2'h2;
    localparam logic [1:0] FLASH_PWR_MID = 2'h1;
    localparam logic [1:0] FLASH_PWR_LOW = 2'h0;

    // Brown-out modes.
    localparam logic [1:0] BOR_ALWAYS = 2'h3;
    localparam logic [1:0] BOR_AWAKE = 2'h2;
    localparam logic [1:0] BOR_SOFT = 2'h1;
    localparam logic [1:0] BOR_OFF = 2'h0;

    // Register byte offsets on the bus.
    localparam logic [11:0] REG_OSC_WORD = 12'h000;
    localparam logic [11:0] REG_SUP_WORD = 12'h004;
    localparam logic [11:0] REG_PROG_WORD = 12'h008;
    localparam logic [11:0] REG_CLOCK_CTRL = 12'h00c;
    localparam logic [11:0] REG_FEATURE_CTRL = 12'h010;
    localparam logic [11:0] REG_STATUS = 12'h014;

    // Field positions inside the bus registers.
    localparam int PROG_LVP_BIT = 0;
    localparam int PROG_GUARD_BIT = 1;
    localparam int CLK_NEWOSC_LSB = 0;
    localparam int CLK_NEWDIV_LSB = 4;
    localparam int CLK_CUROSC_LSB = 8;
    localparam int CLK_CURDIV_LSB = 12;
    localparam int FEAT_ZCD_SOFT_BIT = 0;
    localparam int FEAT_BOR_SOFT_BIT = 1;
    localparam int FEAT_LOCK_BIT = 2;
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_UNF_BIT = 1;
    localparam int STAT_VALID_BIT = 2;
    localparam int STAT_STUCK_BIT = 3;

    typedef enum logic [1:0] {SRC_EXTERNAL, SRC_FAST_INTERNAL, SRC_SLOW_INTERNAL} src_t;
    typedef enum logic {PH_LOAD, PH_RUN} phase_t;

    typedef struct packed {
        logic clock_fail_monitor_on;
        logic clock_switch_allow;
        logic clock_output_active;
        logic [2:0] reset_oscillator_choice;
        src_t source;
        logic pll_x2;
        logic pll_x4;
        logic [2:0] internal_frequency_code;
        logic [3:0] clock_divider_code;
        logic [2:0] external_oscillator_mode;
        logic external_clock_input_mode;
        logic crystal_mode;
        logic [1:0] flash_power_level;
    } osc_cfg_t;

    typedef struct packed {
        logic debugger_on;
        logic stack_fault_reset_on;
        logic remap_lock_once;
        logic zero_cross_off;
        logic brownout_level;
        logic [1:0] brownout_mode;
        logic ultra_low_brownout_on;
        logic powerup_timer_on;
        logic reset_pin_function;
        logic high_voltage_programming;
        logic code_guard_on;
    } sup_cfg_t;

endpackage : config_word_pkg

// ---- verif/test_config_word_decode.sv ----
// Self-checking testbench for the configuration word decoder.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
        n_errors++; \
        $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module test_config_word_decode;
    import config_word_pkg::*;
    typedef struct packed {
        logic [13:0] osc;
        logic [13:0] sup;
        logic low_voltage_programming;
        logic grd;
        logic [2:0] frq;
        logic [3:0] div;
        logic [1:0] pwr;
        logic ck;
    } row_t;
    // Unused word bits other than oscillator bit 3 are cleared in row 1 so that read-back must set them.
    localparam row_t ROWS [8] = '{
        '{14'h3fff, 14'h3fff, 1'b1, 1'b1, 3'h0, 4'h0, 2'h2, 1'b0},
        '{14'h006e, 14'h0000, 1'b0, 1'b0, 3'h2, 4'h2, 2'h1, 1'b1},
        '{14'h3edd, 14'h319d, 1'b0, 1'b1, 3'h0, 4'h0, 2'h0, 1'b1},
        '{14'h16ac, 14'h0f7e, 1'b1, 1'b0, 3'h0, 4'h0, 2'h0, 1'b1},
        '{14'h169a, 14'h3fff, 1'b0, 1'b1, 3'h5, 4'h0, 2'h2, 1'b0},
        '{14'h1689, 14'h011c, 1'b1, 1'b1, 3'h6, 4'h0, 2'h1, 1'b0},
        '{14'h1788, 14'h319d, 1'b0, 1'b0, 3'h6, 4'h0, 2'h0, 1'b0},
        '{14'h16cb, 14'h3fff, 1'b0, 1'b0, 3'h2, 4'h0, 2'h0, 1'b0}};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [13:0] osc_word = 14'h0;
    logic [13:0] sup_word = 14'h0;
    logic low_voltage_programming = 1'b0;
    logic grd = 1'b0;
    logic sleep = 1'b0;
    logic ovf = 1'b0;
    logic unf = 1'b0;
    logic pin = 1'b0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, config_valid, zc_on, bor_on, locked, stk_rst, ext_rst, pin_val;
    osc_cfg_t osc_cfg;
    sup_cfg_t sup_cfg;
    logic [2:0] cur_osc, rc;
    logic [3:0] cur_div;
    src_t es;
    row_t r;
    int n_errors = 0;
    int samples_checked = 0;

    config_word_decode dut (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .OSC_WORD(osc_word), .SUP_WORD(sup_word),
        .LOW_VOLTAGE_PROGRAMMING(low_voltage_programming), .CODE_GUARD_BIT(grd), .SLEEP(sleep),
        .STACK_OVERFLOW(ovf), .STACK_UNDERFLOW(unf), .SHARED_INPUT_PIN(pin),
        .CONFIG_VALID(config_valid), .OSC_CFG(osc_cfg), .SUP_CFG(sup_cfg),
        .CURRENT_OSCILLATOR(cur_osc), .CURRENT_DIVIDER(cur_div), .ZERO_CROSS_ON(zc_on),
        .BROWNOUT_ON(bor_on), .REMAP_LOCKED(locked), .STACK_RESET(stk_rst),
        .EXTERNAL_RESET(ext_rst), .SHARED_INPUT_VALUE(pin_val));

    always #2 clk = ~clk;

    // The request is held until pready is seen high at a rising edge, then released.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle();
        repeat (3) @(negedge clk);
    endtask : settle

    // Words are changed under reset, so the held outputs must still show a blank part.
    task automatic load(input row_t x);
        @(posedge clk);
        nrst <= 1'b0;
        osc_word <= x.osc;
        sup_word <= x.sup;
        low_voltage_programming <= x.low_voltage_programming;
        grd <= x.grd;
        sleep <= 1'b0;
        pin <= 1'b0;
        @(negedge clk);
        `CHK("valid_rst", 1'b0, config_valid)
        `CHK("reset_oscillator_choice_rst", 3'h7, osc_cfg.reset_oscillator_choice)
        `CHK("debug_rst", 1'b0, sup_cfg.debugger_on)
        @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask : load

    task automatic stack(input logic under, input logic exp);
        @(posedge clk);
        ovf <= ~under;
        unf <= under;
        @(posedge clk);
        ovf <= 1'b0;
        unf <= 1'b0;
        @(negedge clk);
        `CHK("stack_rst", exp, stk_rst)
        @(negedge clk);
        `CHK("stack_rst_end", 1'b0, stk_rst)
    endtask : stack

    task automatic lock_cycle(input logic exp);
        apb(1'b1, REG_FEATURE_CTRL, 32'h4);
        apb(1'b1, REG_FEATURE_CTRL, 32'h0);
        settle();
        `CHK("remap_locked", exp, locked)
    endtask : lock_cycle

    task automatic complete_run();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        foreach (ROWS[i]) begin
            r = ROWS[i];
            load(r);
            rc = r.osc[6:4];
            es = (rc == 3'h7 || rc == 3'h2) ? SRC_EXTERNAL :
                 (rc == 3'h5) ? SRC_SLOW_INTERNAL : SRC_FAST_INTERNAL;
            `CHK("valid", 1'b1, config_valid)
            `CHK("fail_mon", r.osc[13], osc_cfg.clock_fail_monitor_on)
            `CHK("switch", r.osc[11], osc_cfg.clock_switch_allow)
            `CHK("clk_out", r.ck, osc_cfg.clock_output_active)
            `CHK("reset_oscillator_choice", rc, osc_cfg.reset_oscillator_choice)
            `CHK("cur_osc", rc, cur_osc)
            `CHK("source", es, osc_cfg.source)
            `CHK("pll4", rc == 3'h2, osc_cfg.pll_x4)
            `CHK("pll2", rc == 3'h1, osc_cfg.pll_x2)
            if (rc inside {3'h6, 3'h1, 3'h0, 3'h4}) begin
                `CHK("freq", r.frq, osc_cfg.internal_frequency_code)
                `CHK("div", r.div, osc_cfg.clock_divider_code)
                `CHK("cur_div", r.div, cur_div)
            end
            `CHK("ext_mode", r.osc[2:0], osc_cfg.external_oscillator_mode)
            `CHK("ext_clk", r.osc[2] & |r.osc[1:0], osc_cfg.external_clock_input_mode)
            `CHK("crystal", ~r.osc[2] & ~&r.osc[1:0], osc_cfg.crystal_mode)
            `CHK("flash_pwr", r.pwr, osc_cfg.flash_power_level)
            `CHK("debug", ~r.sup[13], sup_cfg.debugger_on)
            `CHK("stack_on", r.sup[12], sup_cfg.stack_fault_reset_on)
            `CHK("remap_once", r.sup[11], sup_cfg.remap_lock_once)
            `CHK("zcd_off", r.sup[10], sup_cfg.zero_cross_off)
            `CHK("zcd_on", ~r.sup[10], zc_on)
            `CHK("bor_lvl", r.sup[9], sup_cfg.brownout_level)
            `CHK("bor_mode", r.sup[7:6], sup_cfg.brownout_mode)
            `CHK("bor_on", r.sup[7], bor_on)
            `CHK("ulp_bor", ~r.sup[5], sup_cfg.ultra_low_brownout_on)
            `CHK("pwrt", ~r.sup[1], sup_cfg.powerup_timer_on)
            `CHK("pin_fn", r.low_voltage_programming | r.sup[0], sup_cfg.reset_pin_function)
            `CHK("ext_rst", r.low_voltage_programming | r.sup[0], ext_rst)
            `CHK("pin_val", r.low_voltage_programming | r.sup[0], pin_val)
            `CHK("hv_prog", ~r.low_voltage_programming, sup_cfg.high_voltage_programming)
            `CHK("guard", ~r.grd, sup_cfg.code_guard_on)
            apb(1'b0, REG_OSC_WORD, 32'h0);
            `CHK("osc_rd", {18'h0, r.osc | OSC_UNUSED_MASK}, rd)
            apb(1'b0, REG_SUP_WORD, 32'h0);
            `CHK("sup_rd", {18'h0, r.sup | SUP_UNUSED_MASK}, rd)
            apb(1'b0, REG_PROG_WORD, 32'h0);
            `CHK("prog_rd", {30'h0, r.grd, r.low_voltage_programming}, rd)
        end
        load(ROWS[0]);
        apb(1'b1, REG_CLOCK_CTRL, 32'h35);
        settle();
        `CHK("sw_osc", 3'h5, cur_osc)
        `CHK("sw_div", 4'h3, cur_div)
        stack(1'b0, 1'b1);
        stack(1'b1, 1'b1);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("flags", 32'h7, rd & 32'h7)
        apb(1'b1, REG_STATUS, 32'h3);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("flags_clr", 32'h4, rd & 32'h7)
        lock_cycle(1'b1);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("stuck", 32'hc, rd & 32'hf)
        apb(1'b1, REG_OSC_WORD, 32'h0);
        apb(1'b0, REG_OSC_WORD, 32'h0);
        `CHK("ro_word", 32'h3fff, rd)
        apb(1'b0, 12'h020, 32'h0);
        `CHK("unmapped_err", 1'b1, err)
        `CHK("unmapped_rd", 32'h0, rd)
        load(ROWS[1]);
        apb(1'b1, REG_CLOCK_CTRL, 32'h35);
        settle();
        `CHK("sw_blocked", 3'h6, cur_osc)
        stack(1'b0, 1'b0);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("flag_no_rst", 32'h5, rd & 32'h7)
        lock_cycle(1'b0);
        @(posedge clk);
        pin <= 1'b1;
        settle();
        `CHK("gpio_val", 1'b1, pin_val)
        load(ROWS[3]);
        apb(1'b1, REG_FEATURE_CTRL, 32'h3);
        settle();
        `CHK("zcd_soft", 1'b1, zc_on)
        `CHK("bor_soft", 1'b1, bor_on)
        load(ROWS[2]);
        @(posedge clk);
        sleep <= 1'b1;
        pin <= 1'b1;
        settle();
        `CHK("bor_sleep", 1'b0, bor_on)
        `CHK("pin_high", 1'b0, ext_rst)
        complete_run();
    end

    // Whole run is a few hundred cycles; this bound only cuts a hang short.
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule : test_config_word_decode
